/* File: logic/brpe_pkg.sv */
// Summary of operation
// R1: Start address is word aligned, bits 11:8 in high register, 7:2 in low.
// R2: Software programs address, then count, then writes a start bit.
// R3: Address and count registers advance with a control bit 6 read while busy.
// R4: Software leaves address and count alone until done is set.
// R5: Control bit 7 reads the wrapper area into bytes 00-1E, then self-clears.
// R6: Control bit 6 reads count bytes from address, sets done, self-clears.
// R7: Both start bits together run only the wrapper area read.
// R8: Software never programs a byte count above 32.
// R9: Address, control and count registers reset to zero.
// R10: Bytes land in result registers in order from byte 00.
// R11: Lock key unlocks configuration writes only while it holds 56h.
// R12: Reserved bits in control, address and count ignore writes, read zero.
package brpe_pkg;
    localparam int          BUS_AW       = 8;
    localparam int          BUS_DW       = 8;
    localparam int          RAM_AW       = 12;
    localparam int          RES_DEPTH    = 32;
    localparam int          RES_IW       = 5;
    localparam int          CNT_W        = 6;

    localparam logic [7:0]  OFS_RES_BASE = 8'hc0;
    localparam logic [7:0]  OFS_ADDR_HI  = 8'he0;
    localparam logic [7:0]  OFS_ADDR_LO  = 8'he1;
    localparam logic [7:0]  OFS_CONTROL  = 8'he2;
    localparam logic [7:0]  OFS_COUNT    = 8'he3;
    localparam logic [7:0]  OFS_STATUS   = 8'he8;
    localparam logic [7:0]  OFS_LOCK_KEY = 8'heb;

    localparam int          CTRL_WRAP_BIT = 7;
    localparam int          CTRL_ADDR_BIT = 6;
    localparam int          STAT_DONE_BIT = 0;
    localparam logic [7:0]  MASK_ADDR_HI = 8'h0f;
    localparam logic [7:0]  MASK_ADDR_LO = 8'hfc;
    localparam logic [7:0]  MASK_COUNT   = 8'h3f;

    localparam logic [7:0]  RST_REG      = 8'h00;
    localparam logic [7:0]  RST_LOCK_KEY = 8'h56;
    localparam logic [7:0]  KEY_UNLOCK   = 8'h56;
    localparam logic [CNT_W-1:0] WRAP_LEN = 6'h1f;
    localparam logic [RAM_AW-1:0] WRAP_BASE_DEF = 12'h000;

    typedef enum logic [1:0] {
        BRPE_IDLE,
        BRPE_FETCH,
        BRPE_STORE
    } brpe_state_t;
endpackage

/* File: logic/brpe_result_mem.sv */
`timescale 1ns/1ps
module brpe_result_mem #(
    parameter int W  = 8,
    parameter int D  = 32,
    parameter int AW = 5
) (
    input  wire logic          clk,    // Core clock
    input  wire logic          arst_n, // Async reset, active low
    input  wire logic          we,     // Write enable
    input  wire logic [AW-1:0] waddr,  // Write index
    input  wire logic [W-1:0]  wdata,  // Write data
    input  wire logic          re,     // Read enable
    input  wire logic [AW-1:0] raddr,  // Read index
    output logic      [W-1:0]  rdata   // Registered read data
);
    logic [W-1:0] mem [D];

    always_ff @(posedge clk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rdata <= '0;
        end else if (re) begin
            rdata <= mem[raddr];
        end
    end
endmodule // brpe_result_mem

/* File: logic/brpe_top.sv */
// The plain strobed port is this design's own decision.
`timescale 1ns/1ps
module brpe_top #(
    parameter logic [brpe_pkg::RAM_AW-1:0] WRAP_BASE = brpe_pkg::WRAP_BASE_DEF
) (
    input  wire logic                        core_clk,    // 250 MHz core clock
    input  wire logic                        arst_n,      // Async reset, active low
    input  wire logic [brpe_pkg::BUS_AW-1:0] reg_addr,    // Register address
    input  wire logic [brpe_pkg::BUS_DW-1:0] reg_wdata,   // Register write data
    input  wire logic                        reg_wr,      // Write strobe
    input  wire logic                        reg_rd,      // Read strobe
    output logic      [brpe_pkg::BUS_DW-1:0] reg_rdata,   // Read data, cycle after strobe
    output logic                             ram_rd_en,   // Buffer RAM read enable
    output logic      [brpe_pkg::RAM_AW-1:0] ram_rd_addr, // Buffer RAM byte address
    input  wire logic [7:0]                  ram_rd_data, // Buffer RAM data, one cycle later
    output logic                             cfg_unlock,  // Configuration writes allowed
    output logic                             peek_busy    // Engine running
);
    import brpe_pkg::*;

    brpe_state_t       state_r;
    logic [9:0]        addr_word_r;
    logic [CNT_W-1:0]  count_r;
    logic              wrap_go_r;
    logic              addr_go_r;
    logic              done_r;
    logic [7:0]        key_r;
    logic [RAM_AW-1:0] ptr_r;
    logic [CNT_W-1:0]  rem_r;
    logic [RES_IW-1:0] idx_r;
    logic              wrap_mode_r;
    logic              sel_mem_r;
    logic [7:0]        other_q_r;
    logic [7:0]        mem_q;

    logic              wr_ctrl;
    logic              start;
    logic              start_wrap;
    logic [RAM_AW-1:0] start_ptr;
    logic [CNT_W-1:0]  start_len;
    logic              store;
    logic              finish;
    logic [RAM_AW-1:0] ptr_inc;
    logic              in_result;

    function automatic logic [7:0] reg_view(input logic [7:0] a,
                                            input logic [9:0] aw,
                                            input logic [CNT_W-1:0] cnt,
                                            input logic gw, input logic ga,
                                            input logic dn, input logic [7:0] key);
        logic [7:0] v;
        v = 8'h00;
        unique case (a)
            OFS_ADDR_HI:  v = {4'h0, aw[9:6]};             // R1 R12
            OFS_ADDR_LO:  v = {aw[5:0], 2'h0};             // R1 R12
            OFS_CONTROL:  v = {gw, ga, 6'h00};             // R12
            OFS_COUNT:    v = {2'h0, cnt};                 // R12
            OFS_STATUS:   v = {7'h00, dn};
            OFS_LOCK_KEY: v = key;
            default:      v = 8'h00;
        endcase
        return v;
    endfunction

    assign wr_ctrl    = reg_wr && (reg_addr == OFS_CONTROL);
    assign start      = wr_ctrl && (state_r == BRPE_IDLE)
                        && (reg_wdata[CTRL_WRAP_BIT] || reg_wdata[CTRL_ADDR_BIT]);
    assign start_wrap = reg_wdata[CTRL_WRAP_BIT];          // R7
    assign start_ptr  = start_wrap ? WRAP_BASE : {addr_word_r, 2'h0}; // R5 R6
    assign start_len  = start_wrap ? WRAP_LEN : count_r;   // R5 R6
    assign store      = (state_r == BRPE_STORE);
    assign finish     = (store && (rem_r == 6'h01)) || (start && (start_len == '0));
    assign ptr_inc    = ptr_r + 12'h001;
    assign in_result  = (reg_addr[7:5] == OFS_RES_BASE[7:5]);

    // Engine sequencing: one RAM read issued, data captured the next cycle
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            state_r     <= BRPE_IDLE;
            ptr_r       <= '0;
            rem_r       <= '0;
            idx_r       <= '0;
            wrap_mode_r <= 1'b0;
            ram_rd_en   <= 1'b0;
            ram_rd_addr <= '0;
        end else begin
            unique case (state_r)
                BRPE_IDLE: begin
                    if (start && (start_len != '0)) begin
                        state_r     <= BRPE_FETCH;
                        ptr_r       <= start_ptr;
                        rem_r       <= start_len;
                        idx_r       <= '0;                 // R10
                        wrap_mode_r <= start_wrap;
                        ram_rd_en   <= 1'b1;
                        ram_rd_addr <= start_ptr;
                    end
                end
                BRPE_FETCH: begin
                    state_r   <= BRPE_STORE;
                    ram_rd_en <= 1'b0;
                end
                BRPE_STORE: begin
                    ptr_r <= ptr_inc;
                    rem_r <= rem_r - 6'h01;
                    idx_r <= idx_r + 5'h01;                // R10
                    if (rem_r == 6'h01) begin
                        state_r <= BRPE_IDLE;
                    end else begin
                        state_r     <= BRPE_FETCH;
                        ram_rd_en   <= 1'b1;
                        ram_rd_addr <= ptr_inc;
                    end
                end
            endcase
        end
    end

    // Start address: software writes when idle, engine advances it during control bit 6 reads
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            addr_word_r <= {RST_REG[3:0], RST_REG[7:2]};   // R9
        end else if (store && !wrap_mode_r) begin
            addr_word_r <= ptr_inc[11:2];                  // R3
        end else if (reg_wr && (reg_addr == OFS_ADDR_HI)) begin
            addr_word_r[9:6] <= reg_wdata[3:0] & MASK_ADDR_HI[3:0]; // R1 R12
        end else if (reg_wr && (reg_addr == OFS_ADDR_LO)) begin
            addr_word_r[5:0] <= reg_wdata[7:2] & MASK_ADDR_LO[7:2]; // R1 R12
        end
    end

    // Byte count: software writes when idle, engine counts it down during control bit 6 reads
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            count_r <= RST_REG[CNT_W-1:0];                 // R9
        end else if (store && !wrap_mode_r) begin
            count_r <= rem_r - 6'h01;                      // R3
        end else if (reg_wr && (reg_addr == OFS_COUNT)) begin
            count_r <= reg_wdata[CNT_W-1:0] & MASK_COUNT[CNT_W-1:0]; // R12
        end
    end

    // Start bits stand while the engine runs and clear on completion
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            wrap_go_r <= 1'b0;                             // R9
            addr_go_r <= 1'b0;                             // R9
        end else if (finish) begin
            wrap_go_r <= 1'b0;                             // R5
            addr_go_r <= 1'b0;                             // R6
        end else if (start) begin
            wrap_go_r <= start_wrap;                       // R5 R7
            addr_go_r <= !start_wrap;                      // R6 R7
        end
    end

    // Done flag: write 1 clears, a completion in the same cycle wins
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            done_r <= 1'b0;
        end else if (finish) begin
            done_r <= 1'b1;                                // R5 R6
        end else if (reg_wr && (reg_addr == OFS_STATUS) && reg_wdata[STAT_DONE_BIT]) begin
            done_r <= 1'b0;
        end
    end

    // Lock key and the unlock level it drives
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            key_r      <= RST_LOCK_KEY;
            cfg_unlock <= 1'b1;                            // R11
        end else if (reg_wr && (reg_addr == OFS_LOCK_KEY)) begin
            key_r      <= reg_wdata;
            cfg_unlock <= (reg_wdata == KEY_UNLOCK);       // R11
        end
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            peek_busy <= 1'b0;
        end else if (finish) begin
            peek_busy <= 1'b0;
        end else if (start) begin
            peek_busy <= 1'b1;
        end
    end

    // Read path: result bytes come from the memory register, others from here
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            sel_mem_r <= 1'b0;
            other_q_r <= 8'h00;
        end else if (reg_rd) begin
            sel_mem_r <= in_result;
            other_q_r <= reg_view(reg_addr, addr_word_r, count_r, wrap_go_r,
                                  addr_go_r, done_r, key_r);
        end
    end

    assign reg_rdata = sel_mem_r ? mem_q : other_q_r;

    brpe_result_mem #(
        .W  (8),
        .D  (RES_DEPTH),
        .AW (RES_IW)
    ) u_result (
        .clk    (core_clk),
        .arst_n (arst_n),
        .we     (store),                                   // R10
        .waddr  (idx_r),
        .wdata  (ram_rd_data),
        .re     (reg_rd && in_result),
        .raddr  (reg_addr[RES_IW-1:0]),
        .rdata  (mem_q)
    );
endmodule // brpe_top

/* File: test/brpe_ram_model.sv */
`timescale 1ns/1ps
module brpe_ram_model (
    input  wire logic        clk,     // Core clock
    input  wire logic        rd_en,   // Read enable
    input  wire logic [11:0] rd_addr, // Byte address
    output logic      [7:0]  rd_data  // Data, one cycle after enable
);
    initial rd_data = 8'h3c;
    // Outside the answer cycle the bus toggles so stale data never looks valid
    always @(posedge clk) begin
        if (rd_en) begin
            rd_data <= rd_addr[7:0] ^ {rd_addr[11:8], rd_addr[11:8]} ^ 8'h96;
        end else begin
            rd_data <= ~rd_data;
        end
    end
endmodule // brpe_ram_model

/* File: test/brpe_monitor.sv */
`timescale 1ns/1ps
module brpe_monitor #(
    parameter logic [brpe_pkg::RAM_AW-1:0] WRAP_BASE = brpe_pkg::WRAP_BASE_DEF
) (
    input wire logic                        core_clk,    // Core clock
    input wire logic                        arst_n,      // Async reset
    input wire logic [brpe_pkg::BUS_AW-1:0] reg_addr,    // Address
    input wire logic [brpe_pkg::BUS_DW-1:0] reg_wdata,   // Write data
    input wire logic                        reg_wr,      // Write strobe
    input wire logic                        reg_rd,      // Read strobe
    input wire logic [brpe_pkg::BUS_DW-1:0] reg_rdata,   // Read data
    input wire logic                        ram_rd_en,   // RAM read enable
    input wire logic [brpe_pkg::RAM_AW-1:0] ram_rd_addr, // RAM address
    input wire logic                        cfg_unlock,  // Unlocked
    input wire logic                        peek_busy    // Engine running
);
    import brpe_pkg::*;
    default clocking @(posedge core_clk); endclocking
    default disable iff (!arst_n);
    logic       wrap_r;
    logic [5:0] pulses_r;
    wire        go_w = reg_wr && reg_addr == OFS_CONTROL && !peek_busy;
    // Counts RAM reads of the running transfer
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            wrap_r   <= 1'b0;
            pulses_r <= 6'h00;
        end else if (go_w) begin
            wrap_r   <= reg_wdata[7];
            pulses_r <= 6'h00;
        end else if (ram_rd_en) begin
            pulses_r <= pulses_r + 6'h01;
        end
    end
    a_rd_en_pulse: assert property (ram_rd_en |=> !ram_rd_en)
        else $error("read enable longer than one cycle");
    a_rd_en_busy: assert property (ram_rd_en |-> peek_busy)
        else $error("read enable while idle");
    a_addr_step: assert property ((ram_rd_en && peek_busy) ##1 peek_busy ##1
        (ram_rd_en && peek_busy) |-> ram_rd_addr == $past(ram_rd_addr, 2) + 1'b1)
        else $error("buffer address not sequential");
    a_wrap_first: assert property (go_w && reg_wdata[7]
        |=> peek_busy && ram_rd_en && ram_rd_addr == WRAP_BASE)
        else $error("wrapper read start wrong");
    a_wrap_len: assert property ($fell(peek_busy) && wrap_r |-> pulses_r == 6'd31)
        else $error("wrapper read length wrong");
    a_busy_bound: assert property ($rose(peek_busy) |-> ##[1:66] !peek_busy)
        else $error("transfer does not finish");
    a_unlock_key: assert property (reg_wr && reg_addr == OFS_LOCK_KEY
        |=> cfg_unlock == ($past(reg_wdata) == KEY_UNLOCK))
        else $error("unlock does not follow key");
    a_unmapped_zero: assert property (reg_rd && reg_addr inside {[8'he4:8'he7], 8'hea}
        |=> reg_rdata == 8'h00)
        else $error("unmapped read not zero");
    a_ctrl_reserved: assert property (reg_rd && reg_addr == OFS_CONTROL
        |=> reg_rdata[5:0] == 6'h00)
        else $error("control reserved bits not zero");
    c_wrap: cover property (go_w && reg_wdata[7]);
    c_addressed: cover property (go_w && reg_wdata[6] && !reg_wdata[7]);
    c_done: cover property ($fell(peek_busy));
endmodule // brpe_monitor

bind brpe_top brpe_monitor #(.WRAP_BASE(WRAP_BASE)) i_brpe_monitor (
    .core_clk(core_clk), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ram_rd_en(ram_rd_en),
    .ram_rd_addr(ram_rd_addr), .cfg_unlock(cfg_unlock), .peek_busy(peek_busy));

/* File: test/tb_top.sv */
`timescale 1ns/1ps
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin n_errors++; \
    $display("[ERR] %0t got %h exp %h", $time, g, e); end end
module tb_top;
    import brpe_pkg::*;
    localparam logic [RAM_AW-1:0] WBASE = 12'h3a0;
    logic        core_clk = 1'b0, arst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
    logic [7:0]  reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, ram_rd_data;
    logic [11:0] ram_rd_addr;
    logic        ram_rd_en, cfg_unlock, peek_busy;
    logic [31:0] seed = 32'h53f1;
    int          n_errors = 0, n_checks = 0, n_pulse = 0;
    always #2 core_clk = ~core_clk;
    always @(posedge core_clk) if (ram_rd_en === 1'b1) n_pulse++;
    brpe_top #(.WRAP_BASE(WBASE)) i_brpe_top (.core_clk(core_clk), .arst_n(arst_n),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .ram_rd_en(ram_rd_en), .ram_rd_addr(ram_rd_addr),
        .ram_rd_data(ram_rd_data), .cfg_unlock(cfg_unlock), .peek_busy(peek_busy));
    brpe_ram_model i_brpe_ram_model (.clk(core_clk), .rd_en(ram_rd_en),
        .rd_addr(ram_rd_addr), .rd_data(ram_rd_data));
    function automatic logic [7:0] mem(input logic [11:0] a);
        return a[7:0] ^ {a[11:8], a[11:8]} ^ 8'h96;
    endfunction
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk);
        reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= d;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge core_clk);
        reg_rd <= 1'b1; reg_addr <= a;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        @(negedge core_clk);
        d = reg_rdata;
    endtask
    task automatic chk_rd(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] d;
        rd(a, d);
        `CHK(d, e)
    endtask
    // Program, launch, wait, then compare results against the queue model
    task automatic xfer(input logic [11:0] a, input logic [5:0] n, input logic [7:0] go);
        logic [7:0] q[$];
        logic [7:0] d;
        int         np;
        wr(OFS_ADDR_HI, {4'h0, a[11:8]});
        wr(OFS_ADDR_LO, a[7:0]);
        wr(OFS_COUNT, {2'b00, n});
        n_pulse = 0;
        wr(OFS_CONTROL, go);
        if (go[7]) begin
            chk_rd(OFS_CONTROL, 8'h80);
            wr(OFS_CONTROL, 8'h40);
        end
        repeat (2) @(negedge core_clk);
        for (int i = 0; i < 200 && peek_busy !== 1'b0; i++) @(negedge core_clk);
        `CHK(peek_busy, 1'b0)
        np = go[7] ? 31 : int'(n);
        for (int k = 0; k < np; k++) q.push_back(mem(go[7] ? 12'(WBASE + k) : 12'({a[11:2], 2'b00} + k)));
        `CHK(n_pulse, np)
        rd(OFS_STATUS, d);
        `CHK(d[STAT_DONE_BIT], 1'b1)
        chk_rd(OFS_CONTROL, 8'h00);
        foreach (q[k]) chk_rd(OFS_RES_BASE + 8'(k), q[k]);
        if (go[7]) chk_rd(OFS_COUNT, {2'b00, n});
        else chk_rd(OFS_COUNT, 8'h00);
        wr(OFS_STATUS, 8'h01);
        chk_rd(OFS_STATUS, 8'h00);
    endtask
    task automatic final_report();
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    initial begin
        #100000;
        n_errors++;
        final_report();
    end
    initial begin
        logic [31:0] r;
        repeat (4) @(posedge core_clk);
        arst_n <= 1'b1;
        chk_rd(OFS_ADDR_HI, RST_REG);
        chk_rd(OFS_ADDR_LO, RST_REG);
        chk_rd(OFS_CONTROL, RST_REG);
        chk_rd(OFS_COUNT, RST_REG);
        chk_rd(OFS_LOCK_KEY, RST_LOCK_KEY);
        `CHK(cfg_unlock, 1'b1)
        chk_rd(8'he5, 8'h00);
        wr(OFS_ADDR_HI, 8'hff); wr(OFS_ADDR_LO, 8'hff);
        wr(OFS_COUNT, 8'he0); wr(OFS_CONTROL, 8'h3f);
        chk_rd(OFS_ADDR_HI, MASK_ADDR_HI);
        chk_rd(OFS_ADDR_LO, MASK_ADDR_LO);
        chk_rd(OFS_COUNT, 8'he0 & MASK_COUNT);
        chk_rd(OFS_CONTROL, 8'h00);
        `CHK(peek_busy, 1'b0)
        wr(OFS_LOCK_KEY, 8'h00);
        chk_rd(OFS_LOCK_KEY, 8'h00);
        `CHK(cfg_unlock, 1'b0)
        wr(OFS_LOCK_KEY, KEY_UNLOCK);
        chk_rd(OFS_LOCK_KEY, KEY_UNLOCK);
        `CHK(cfg_unlock, 1'b1)
        xfer(12'hffc, 6'd1, 8'h40);
        xfer(12'h404, 6'd32, 8'h40);
        xfer(12'h120, 6'd0, 8'h40);
        xfer(12'h35c, 6'd7, 8'hc0);
        for (int i = 0; i < 4; i++) begin
            r = rnd();
            xfer({1'b0, r[10:0]}, 6'(r[20:16] + 5'd1), {r[31], 7'h40});
        end
        final_report();
    end
endmodule // tb_top
